// [design/aer_uncorr_pkg.sv]
// Contract
// - Next-capability pointer reads constant 150h
// - Version reads 2h; word reads 1502h
// - Status bits clear only on write-1
// - Unsupported request sets status bit 20
// - End-to-end CRC failure sets bit 19
// - Malformed packet sets status bit 18
// - Credit overflow sets status bit 17
// - Stray completion sets status bit 16
// - Own completer abort sets bit 15
// - Completion timeout sets status bit 14
// - Flow-control protocol error sets bit 13
// - Poisoned packet sets status bit 12
// - Data link protocol error sets bit 4
// - Reserved bits read zero, ignore writes
// - Masked error never updates any status
// - Mask bits read/write at implemented positions
// - All resets clear status and mask
package aer_uncorr_pkg;

    // --------------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------------
    localparam logic [11:0] OFF_NEXT_CAP_VERSION = 12'h102;
    localparam logic [11:0] OFF_UNCORR_STATUS    = 12'h104;
    localparam logic [11:0] OFF_UNCORR_MASK      = 12'h108;

    localparam logic [11:0] NEXT_CAP_OFFSET = 12'h150;
    localparam logic [3:0]  CAP_VERSION     = 4'h2;
    localparam logic [15:0] NEXT_CAP_VERSION_VALUE = 16'h1502;

    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;

    // --------------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------------
    localparam int BIT_UNSUPPORTED_REQUEST = 20;
    localparam int BIT_END_TO_END_CRC      = 19;
    localparam int BIT_MALFORMED_PACKET    = 18;
    localparam int BIT_RECEIVER_OVERFLOW   = 17;
    localparam int BIT_STRAY_COMPLETION    = 16;
    localparam int BIT_COMPLETER_ABORT     = 15;
    localparam int BIT_COMPLETION_EXPIRY   = 14;
    localparam int BIT_FLOW_CREDIT         = 13;
    localparam int BIT_POISONED_PACKET     = 12;
    localparam int BIT_LINK_PROTOCOL       = 4;

    localparam int NUM_ERRORS = 10;

    // Implemented bits: 20..12 and 4
    localparam logic [31:0] IMPL_BITS = 32'h001f_f010;

    // One pulse per detector, in bit order 20 down to 12, then 4
    typedef struct packed {
        logic unsupported_request;
        logic end_to_end_crc;
        logic malformed_packet;
        logic receiver_overflow;
        logic stray_completion;
        logic completer_abort;
        logic completion_expiry;
        logic flow_credit;
        logic poisoned_packet;
        logic link_protocol;
    } error_events_t;

    // Configuration access as seen by the register block
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

endpackage

// [design/aer_sticky_bit.sv]
module aer_sticky_bit (
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_event,
    input  wire logic i_suppress,
    input  wire logic i_clear,
    output logic      o_flag
);

    logic flag_reg;
    logic flag_next;

    always_comb begin
        flag_next = flag_reg;
        if (i_clear) begin
            flag_next = 1'b0;
        end
        if (i_event && !i_suppress) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign o_flag = flag_reg;

endmodule

// [design/pcie_aer_uncorrectable_log.sv]
module pcie_aer_uncorrectable_log (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rstn,
    input  wire aer_uncorr_pkg::cfg_req_t      i_cfg_req,
    input  wire aer_uncorr_pkg::error_events_t i_errors,
    output logic [31:0]                        o_cfg_rdata,
    output logic                               o_cfg_rvalid,
    output logic [31:0]                        o_status,
    output logic [31:0]                        o_mask
);

    // --------------------------------------------------------------------
    // Access decode
    // --------------------------------------------------------------------
    logic [31:0] wr_bits;
    logic        wr_status;
    logic        wr_mask;
    logic        wr_version_word;
    logic [31:0] ev_vec;
    logic [31:0] status_vec;
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        rvalid_reg;
    logic        rvalid_next;

    // Byte enables gate the write data; disabled lanes are left alone
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_bits[b*8 +: 8] = i_cfg_req.byte_en[b] ? i_cfg_req.wdata[b*8 +: 8] : 8'h00;
        end
    end

    always_comb begin
        wr_status       = 1'b0;
        wr_mask         = 1'b0;
        wr_version_word = 1'b0;
        if (i_cfg_req.wr && i_cfg_req.addr == aer_uncorr_pkg::OFF_UNCORR_STATUS) begin
            wr_status = 1'b1;
        end else if (i_cfg_req.wr && i_cfg_req.addr == aer_uncorr_pkg::OFF_UNCORR_MASK) begin
            wr_mask = 1'b1;
        end else if (i_cfg_req.wr && i_cfg_req.addr == aer_uncorr_pkg::OFF_NEXT_CAP_VERSION) begin
            // Read-only word: write accepted and dropped
            wr_version_word = 1'b1;
        end
    end

    // --------------------------------------------------------------------
    // Status bits
    // --------------------------------------------------------------------
    // Map detector pulses
    always_comb begin
        ev_vec = 32'h0000_0000;
        ev_vec[aer_uncorr_pkg::BIT_UNSUPPORTED_REQUEST] = i_errors.unsupported_request;
        ev_vec[aer_uncorr_pkg::BIT_END_TO_END_CRC]      = i_errors.end_to_end_crc;
        ev_vec[aer_uncorr_pkg::BIT_MALFORMED_PACKET]    = i_errors.malformed_packet;
        ev_vec[aer_uncorr_pkg::BIT_RECEIVER_OVERFLOW]   = i_errors.receiver_overflow;
        ev_vec[aer_uncorr_pkg::BIT_STRAY_COMPLETION]    = i_errors.stray_completion;
        ev_vec[aer_uncorr_pkg::BIT_COMPLETER_ABORT]     = i_errors.completer_abort;
        ev_vec[aer_uncorr_pkg::BIT_COMPLETION_EXPIRY]   = i_errors.completion_expiry;
        ev_vec[aer_uncorr_pkg::BIT_FLOW_CREDIT]         = i_errors.flow_credit;
        ev_vec[aer_uncorr_pkg::BIT_POISONED_PACKET]     = i_errors.poisoned_packet;
        ev_vec[aer_uncorr_pkg::BIT_LINK_PROTOCOL]       = i_errors.link_protocol;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_status
            if (aer_uncorr_pkg::IMPL_BITS[gi]) begin : g_impl
                aer_sticky_bit u_bit (
                    .i_clk_sys  (i_clk_sys),
                    .i_rstn     (i_rstn),
                    .i_event    (ev_vec[gi]),
                    .i_suppress (mask_reg[gi]),
                    .i_clear    (wr_status && wr_bits[gi]),
                    .o_flag     (status_vec[gi])
                );
            end else begin : g_rsvd
                assign status_vec[gi] = 1'b0;
            end
        end
    endgenerate

    // --------------------------------------------------------------------
    // Mask and read path
    // --------------------------------------------------------------------
    always_comb begin
        mask_next = mask_reg;
        if (wr_mask) begin
            for (int b = 0; b < 4; b++) begin
                if (i_cfg_req.byte_en[b]) begin
                    mask_next[b*8 +: 8] = i_cfg_req.wdata[b*8 +: 8] & aer_uncorr_pkg::IMPL_BITS[b*8 +: 8];
                end
            end
        end
    end

    // Unmapped reads return zero so probing software sees nothing stray
    always_comb begin
        rdata_next  = 32'h0000_0000;
        rvalid_next = i_cfg_req.rd;
        if (i_cfg_req.rd && i_cfg_req.addr == aer_uncorr_pkg::OFF_NEXT_CAP_VERSION) begin
            rdata_next = {16'h0000, aer_uncorr_pkg::NEXT_CAP_OFFSET, aer_uncorr_pkg::CAP_VERSION};
        end else if (i_cfg_req.rd && i_cfg_req.addr == aer_uncorr_pkg::OFF_UNCORR_STATUS) begin
            rdata_next = status_vec;
        end else if (i_cfg_req.rd && i_cfg_req.addr == aer_uncorr_pkg::OFF_UNCORR_MASK) begin
            rdata_next = mask_reg;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_reg   <= aer_uncorr_pkg::MASK_RESET;
            rdata_reg  <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            mask_reg   <= mask_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign o_cfg_rdata  = rdata_reg;
    assign o_cfg_rvalid = rvalid_reg;
    assign o_status     = status_vec;
    assign o_mask       = mask_reg;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    a_version_read: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cfg_req.rd && i_cfg_req.addr == aer_uncorr_pkg::OFF_NEXT_CAP_VERSION)
        |=> (o_cfg_rvalid && o_cfg_rdata == {16'h0000, aer_uncorr_pkg::NEXT_CAP_VERSION_VALUE}))
        else $error("version word wrong");

    a_pointer_field: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cfg_req.rd && i_cfg_req.addr == aer_uncorr_pkg::OFF_NEXT_CAP_VERSION)
        |=> (o_cfg_rdata[15:4] == aer_uncorr_pkg::NEXT_CAP_VERSION_VALUE[15:4]))
        else $error("next pointer wrong");

    a_no_self_clear: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!wr_status) |=> ((o_status & $past(o_status)) == $past(o_status)))
        else $error("status bit dropped without write");

    a_w1c_clears: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_status && wr_bits[aer_uncorr_pkg::BIT_COMPLETER_ABORT] && !i_errors.completer_abort)
        |=> !o_status[aer_uncorr_pkg::BIT_COMPLETER_ABORT])
        else $error("write one did not clear");

    a_ur_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.unsupported_request && !mask_reg[20]) |=> o_status[20])
        else $error("unsupported request not logged");

    a_ecrc_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.end_to_end_crc && !mask_reg[19]) |=> o_status[19])
        else $error("crc failure not logged");

    a_malformed_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.malformed_packet && !mask_reg[18]) |=> o_status[18])
        else $error("malformed packet not logged");

    a_overflow_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.receiver_overflow && !mask_reg[17]) |=> o_status[17])
        else $error("overflow not logged");

    a_stray_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.stray_completion && !mask_reg[16]) |=> o_status[16])
        else $error("stray completion not logged");

    a_abort_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.completer_abort && !mask_reg[15]) |=> o_status[15])
        else $error("completer abort not logged");

    a_expiry_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.completion_expiry && !mask_reg[14]) |=> o_status[14])
        else $error("completion timeout not logged");

    a_flow_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.flow_credit && !mask_reg[13]) |=> o_status[13])
        else $error("flow control error not logged");

    a_poison_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.poisoned_packet && !mask_reg[12]) |=> o_status[12])
        else $error("poisoned packet not logged");

    a_link_sets: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_errors.link_protocol && !mask_reg[4]) |=> o_status[4])
        else $error("link protocol error not logged");

    a_reserved_zero: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        ((o_status | o_mask) & ~aer_uncorr_pkg::IMPL_BITS) == 32'h0000_0000)
        else $error("reserved bit set");

    a_masked_quiet: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (mask_reg[18] && !o_status[18]) |=> !o_status[18])
        else $error("masked error was logged");

    a_mask_writes: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_mask && i_cfg_req.byte_en == 4'hf)
        |=> (o_mask == ($past(i_cfg_req.wdata) & aer_uncorr_pkg::IMPL_BITS)))
        else $error("mask write not stored");

    a_reset_clear: assert property (
        @(posedge i_clk_sys)
        $rose(i_rstn) |-> (o_status == aer_uncorr_pkg::STATUS_RESET && o_mask == aer_uncorr_pkg::MASK_RESET))
        else $error("reset did not clear registers");

    a_set_wins: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_status && wr_bits[20] && i_errors.unsupported_request && !mask_reg[20]) |=> o_status[20])
        else $error("event lost to clear");

    a_version_ro: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        wr_version_word
        |=> (o_mask == $past(o_mask) && (o_status & $past(o_status)) == $past(o_status)))
        else $error("write to read-only word took effect");

    a_answer_quiet: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !i_cfg_req.rd |=> (!o_cfg_rvalid && o_cfg_rdata == 32'h0000_0000))
        else $error("answer without read");

    a_unmapped_zero: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cfg_req.rd && i_cfg_req.addr != aer_uncorr_pkg::OFF_NEXT_CAP_VERSION
         && i_cfg_req.addr != aer_uncorr_pkg::OFF_UNCORR_STATUS
         && i_cfg_req.addr != aer_uncorr_pkg::OFF_UNCORR_MASK)
        |=> (o_cfg_rvalid && o_cfg_rdata == 32'h0000_0000))
        else $error("unmapped read returned data");

    a_status_read: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cfg_req.rd && i_cfg_req.addr == aer_uncorr_pkg::OFF_UNCORR_STATUS)
        |=> (o_cfg_rvalid && o_cfg_rdata == $past(o_status)))
        else $error("status read wrong");

    a_mask_read: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cfg_req.rd && i_cfg_req.addr == aer_uncorr_pkg::OFF_UNCORR_MASK)
        |=> (o_cfg_rvalid && o_cfg_rdata == $past(o_mask)))
        else $error("mask read wrong");

    a_zero_write_keeps: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_status && (wr_bits & aer_uncorr_pkg::IMPL_BITS) == 32'h0000_0000)
        |=> ((o_status & $past(o_status)) == $past(o_status)))
        else $error("zero write cleared a bit");

    a_mask_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !wr_mask |=> (o_mask == $past(o_mask)))
        else $error("mask changed without write");

    a_mask_lane_keep: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (wr_mask && !i_cfg_req.byte_en[2]) |=> (o_mask[23:16] == $past(o_mask[23:16])))
        else $error("disabled lane of mask written");

    // --------------------------------------------------------------------
    // Per-bit checks over the implemented positions
    // --------------------------------------------------------------------
    generate
        for (gi = 0; gi < 32; gi++) begin : g_check
            if (aer_uncorr_pkg::IMPL_BITS[gi]) begin : g_impl
                a_masked_bit: assert property (
                    @(posedge i_clk_sys) disable iff (!i_rstn)
                    (mask_reg[gi] && !o_status[gi]) |=> !o_status[gi])
                    else $error("masked event was logged");

                a_clear_bit: assert property (
                    @(posedge i_clk_sys) disable iff (!i_rstn)
                    (wr_status && wr_bits[gi] && !ev_vec[gi]) |=> !o_status[gi])
                    else $error("write one did not clear bit");

                a_event_bit: assert property (
                    @(posedge i_clk_sys) disable iff (!i_rstn)
                    (ev_vec[gi] && !mask_reg[gi]) |=> o_status[gi])
                    else $error("unmasked event not logged");
            end
        end
    endgenerate

endmodule

// [dv/cfg_host_model.sv]
module cfg_host_model (
    input  wire logic                     i_clk_sys,
    input  wire logic [31:0]              i_rdata,
    input  wire logic                     i_rvalid,
    output aer_uncorr_pkg::cfg_req_t      o_req
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] rdata_got;
    int          fails = 0;

    initial o_req = '0;

    task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                          input logic [31:0] wd);
        @(posedge i_clk_sys);
        #1;
        o_req = '{rd: ~wr, wr: wr, addr: addr, byte_en: be, wdata: wd};
        @(posedge i_clk_sys);
        #1;
        // Idle bus carries junk so that unqualified use of it shows up
        o_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, byte_en: ~be, wdata: ~wd};
        rdata_got = i_rdata;
        if (i_rvalid !== ~wr) begin
            fails++;
            $display("CHECK FAILED at %0t: answer strobe wrong", $time);
        end
    endtask
endmodule

// [dv/pcie_aer_uncorrectable_log_tb.sv]
module pcie_aer_uncorrectable_log_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                          i_clk_sys;
    logic                          i_rstn;
    aer_uncorr_pkg::cfg_req_t      cfg_req;
    aer_uncorr_pkg::error_events_t errs;
    logic [31:0]                   rdata;
    logic                          rvalid;
    logic [31:0]                   status;
    logic [31:0]                   mask;
    logic [31:0]                   st_m = '0;
    logic [31:0]                   mk_m = '0;
    logic [31:0]                   ev_m;
    logic [31:0]                   lane_m;
    logic [31:0]                   exp_v;
    logic [31:0]                   rnd;
    int                            error_cnt = 0;
    int                            samples_checked = 0;

    cfg_host_model host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(cfg_req));

    pcie_aer_uncorrectable_log dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cfg_req(cfg_req),
        .i_errors(errs), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_status(status), .o_mask(mask));

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    assign ev_m = {11'h0, errs[9:1], 7'h0, errs[0], 4'h0};
    assign lane_m = {{8{cfg_req.byte_en[3]}}, {8{cfg_req.byte_en[2]}}, {8{cfg_req.byte_en[1]}},
                     {8{cfg_req.byte_en[0]}}} & 32'h001f_f010;

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st_m <= 32'h0;
            mk_m <= 32'h0;
        end else begin
            st_m <= (st_m & ~((cfg_req.wr && cfg_req.addr == 12'h104) ? (lane_m & cfg_req.wdata) : 32'h0))
                    | (ev_m & ~mk_m);
            if (cfg_req.wr && cfg_req.addr == 12'h108)
                mk_m <= (mk_m & ~lane_m) | (cfg_req.wdata & lane_m);
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    always @(negedge i_clk_sys) begin
        check(status, st_m, "status");
        check(mask, mk_m, "mask");
    end

    task automatic rd(input logic [11:0] addr);
        exp_v = (addr == 12'h102) ? 32'h0000_1502 : (addr == 12'h104) ? st_m : (addr == 12'h108) ? mk_m : 32'h0;
        host.access(1'b0, addr, 4'h0, 32'h0);
        check(host.rdata_got, exp_v, "read");
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] d, input logic [3:0] be);
        host.access(1'b1, addr, be, d);
    endtask

    task automatic pulse(input logic [9:0] e);
        @(posedge i_clk_sys);
        #1;
        errs = e;
        @(posedge i_clk_sys);
        #1;
        errs = '0;
    endtask

    task automatic complete_run();
        error_cnt += host.fails;
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        errs = '0;
        i_rstn = 1'b0;
        void'($urandom(32'h86b874b1));
        repeat (3) @(posedge i_clk_sys);
        #1 i_rstn = 1'b1;
        rd(12'h102);
        rd(12'h104);
        rd(12'h108);
        rd(12'h10c);
        for (int i = 0; i < 10; i++) begin
            pulse(10'h1 << i);
            rd(12'h104);
        end
        wr(12'h104, 32'h0, 4'hf);
        wr(12'h104, 32'hffff_ffff, 4'h5);
        rd(12'h104);
        wr(12'h104, 32'hffff_ffff, 4'hf);
        wr(12'h108, 32'hffff_ffff, 4'hf);
        rd(12'h108);
        wr(12'h102, 32'h0, 4'hf);
        rd(12'h102);
        pulse(10'h3ff);
        rd(12'h104);
        for (int k = 0; k < 24; k++) begin
            rnd = $urandom;
            wr(12'h108, rnd, rnd[7:4]);
            pulse(rnd[9:0]);
            wr(12'h104, {rnd[15:0], rnd[31:16]}, rnd[3:0]);
            rd(12'h104);
        end
        wr(12'h108, 32'h0, 4'hf);
        pulse(10'h3ff);
        fork
            wr(12'h104, 32'hffff_ffff, 4'hf);
            pulse(10'h3ff);
        join
        rd(12'h104);
        wr(12'h108, 32'h000a_5010, 4'hf);
        @(posedge i_clk_sys);
        #1 i_rstn = 1'b0;
        @(posedge i_clk_sys);
        #1 i_rstn = 1'b1;
        rd(12'h104);
        rd(12'h108);
        complete_run();
    end

    // Bounds the whole run in case a task never returns
    initial begin
        #100us;
        error_cnt++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        complete_run();
    end
endmodule
